/* src/bup_pkg.sv */
// Package: constants and types for the unpack-BCD execution block
package bup_pkg;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  localparam logic [3:0]  BUP_OP_HI       = 4'h8;
  localparam logic [4:0]  BUP_OP_MID      = 5'h18;
  localparam int          BUP_FORM_BIT    = 3;
  localparam int          BUP_DST_LSB     = 9;
  localparam int          BUP_SRC_LSB     = 0;

  // ----------------------------------------------------------------
  // Operand forms and widths
  // ----------------------------------------------------------------
  localparam logic        BUP_FORM_REG    = 1'b0;
  localparam logic        BUP_FORM_MEM    = 1'b1;
  localparam logic [31:0] BUP_PREDEC_BYTE = 32'h0000_0001;
  localparam logic [15:0] BUP_ZERO_WORD   = 16'h0000;
  localparam logic [31:0] BUP_ZERO_LONG   = 32'h0000_0000;
  localparam logic [2:0]  BUP_ZERO_REG    = 3'h0;
  localparam logic [7:0]  BUP_ZERO_BYTE   = 8'h00;

  typedef enum logic [8:0] {
    BUP_IDLE   = 9'h001,
    BUP_EXT    = 9'h002,
    BUP_RDREG  = 9'h004,
    BUP_SRCRD  = 9'h008,
    BUP_WRHI   = 9'h010,
    BUP_WRLO   = 9'h020,
    BUP_WRREG  = 9'h040,
    BUP_DONE   = 9'h080,
    BUP_ILLEG  = 9'h100
  } bup_state_t;

endpackage : bup_pkg

/* src/bup_expand.sv */
// Module: nibble expansion and adjustment add
module bup_expand (
  input  wire logic [7:0]  packed_byte,
  input  wire logic [15:0] adjust_word,
  output logic      [15:0] result_word
);
  import bup_pkg::*;

  logic [15:0] spread;

  always_comb begin
    spread      = {4'h0, packed_byte[7:4], 4'h0, packed_byte[3:0]};
    result_word = spread + adjust_word;
  end

endmodule : bup_expand

/* src/bup_core.sv */
// Module: decode and sequencing of the unpack-BCD instruction
module bup_core (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire logic [15:0] op_word,
  output logic             ext_req,
  input  wire logic        ext_ack,
  input  wire logic [15:0] ext_word,
  output logic             rf_rd_en,
  output logic             rf_rd_addr_sel,
  output logic      [2:0]  rf_rd_idx,
  input  wire logic [31:0] rf_rd_data,
  output logic             rf_wr_en,
  output logic             rf_wr_addr_sel,
  output logic      [2:0]  rf_wr_idx,
  output logic      [31:0] rf_wr_data,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output logic             ccr_we,
  output logic             done,
  output logic             illegal
);
  import bup_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bup_state_t  st;
    logic        form;
    logic [2:0]  dst;
    logic [2:0]  src;
    logic [15:0] adj;
    logic [7:0]  sbyte;
    logic [31:0] dreg;
    logic [31:0] daddr;
    logic        rdphase;
    logic [31:0] rf_wdata;
    logic [31:0] maddr;
    logic [7:0]  mwdata;
  } bup_core_t;

  bup_core_t   s_q;
  bup_core_t   s_d;
  logic [15:0] sum_w;
  logic [7:0]  exp_byte;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Opcode match
  function automatic logic is_unpack(input logic [15:0] w);
    is_unpack = (w[15:12] == BUP_OP_HI) && (w[8:4] == BUP_OP_MID);
  endfunction : is_unpack

  // ----------------------------------------------------------------
  // Expansion
  // ----------------------------------------------------------------
  // Memory form expands the byte as it arrives, so that the first
  // write cycle already holds the right high byte even on a fast ack
  assign exp_byte = (s_q.st == BUP_SRCRD) ? mem_rdata : s_q.sbyte;

  bup_expand u_expand (
    .packed_byte (exp_byte),
    .adjust_word (s_q.adj),
    .result_word (sum_w)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      BUP_IDLE: begin
        if (op_valid) begin
          if (is_unpack(op_word)) begin
            s_d.form    = op_word[BUP_FORM_BIT];
            s_d.dst     = op_word[BUP_DST_LSB +: 3];
            s_d.src     = op_word[BUP_SRC_LSB +: 3];
            s_d.rdphase = 1'b0;
            s_d.st      = BUP_EXT;
          end else begin
            s_d.st = BUP_ILLEG;
          end
        end
      end
      BUP_EXT: begin
        if (ext_ack) begin
          s_d.adj = ext_word;
          s_d.st  = BUP_RDREG;
        end
      end
      // Two register reads: source, then destination
      BUP_RDREG: begin
        if (!s_q.rdphase) begin
          s_d.rdphase = 1'b1;
          if (s_q.form == BUP_FORM_REG) begin
            s_d.sbyte = rf_rd_data[7:0];
          end else begin
            s_d.maddr = rf_rd_data - BUP_PREDEC_BYTE;
          end
        end else begin
          s_d.dreg  = rf_rd_data;
          // Destination drops by two bytes; high byte lands at lower address
          s_d.daddr = rf_rd_data - BUP_PREDEC_BYTE - BUP_PREDEC_BYTE;
          if (s_q.form == BUP_FORM_REG) begin
            s_d.st = BUP_WRREG;
          end else begin
            s_d.st = BUP_SRCRD;
          end
        end
      end
      BUP_SRCRD: begin
        if (mem_ack) begin
          s_d.sbyte  = mem_rdata;
          s_d.st     = BUP_WRHI;
        end
      end
      BUP_WRHI: begin
        if (mem_ack) begin
          s_d.st = BUP_WRLO;
        end
      end
      BUP_WRLO: begin
        if (mem_ack) begin
          s_d.st = BUP_WRREG;
        end
      end
      BUP_WRREG: begin
        s_d.st = BUP_DONE;
      end
      BUP_DONE: begin
        s_d.st = BUP_IDLE;
      end
      BUP_ILLEG: begin
        s_d.st = BUP_IDLE;
      end
      default: begin
        s_d.st = BUP_IDLE;
      end
    endcase
    // Registered data outputs
    s_d.mwdata = (s_d.st == BUP_WRLO) ? sum_w[7:0] : sum_w[15:8];
    if (s_d.st == BUP_WRHI) begin
      s_d.maddr = s_d.daddr;
    end else if (s_d.st == BUP_WRLO) begin
      s_d.maddr = s_q.daddr + BUP_PREDEC_BYTE;
    end
    if (s_d.st == BUP_WRREG) begin
      if (s_q.form == BUP_FORM_REG) begin
        s_d.rf_wdata = {s_d.dreg[31:16], sum_w};
      end else begin
        // Only the destination pointer moves; source pointer is not written back
        s_d.rf_wdata = s_d.daddr;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_q <= '{st: BUP_IDLE, form: BUP_FORM_REG, dst: BUP_ZERO_REG, src: BUP_ZERO_REG,
               adj: BUP_ZERO_WORD, sbyte: BUP_ZERO_BYTE, dreg: BUP_ZERO_LONG,
               daddr: BUP_ZERO_LONG, rdphase: 1'b0, rf_wdata: BUP_ZERO_LONG,
               maddr: BUP_ZERO_LONG, mwdata: BUP_ZERO_BYTE};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    op_ready       = (s_q.st == BUP_IDLE);
    ext_req        = (s_q.st == BUP_EXT);
    rf_rd_en       = (s_q.st == BUP_RDREG);
    rf_rd_addr_sel = s_q.form;
    rf_rd_idx      = s_q.rdphase ? s_q.dst : s_q.src;
    // Memory form writes back the decremented destination pointer
    rf_wr_en       = (s_q.st == BUP_WRREG);
    rf_wr_addr_sel = s_q.form;
    rf_wr_idx      = s_q.dst;
    rf_wr_data     = s_q.rf_wdata;
    mem_req        = (s_q.st == BUP_SRCRD) || (s_q.st == BUP_WRHI) || (s_q.st == BUP_WRLO);
    mem_we         = (s_q.st == BUP_WRHI) || (s_q.st == BUP_WRLO);
    mem_addr       = s_q.maddr;
    mem_wdata      = s_q.mwdata;
    ccr_we         = 1'b0;
    done           = (s_q.st == BUP_DONE);
    illegal        = (s_q.st == BUP_ILLEG);
  end

endmodule : bup_core

/* dv/bup_checker.sv */
// Checker: decode, operand and result assertions on bup_core ports
module bup_checker
  import bup_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic [15:0] op_word,
  input wire logic        ext_req,
  input wire logic        ext_ack,
  input wire logic [15:0] ext_word,
  input wire logic        rf_rd_en,
  input wire logic        rf_rd_addr_sel,
  input wire logic [2:0]  rf_rd_idx,
  input wire logic [31:0] rf_rd_data,
  input wire logic        rf_wr_en,
  input wire logic        rf_wr_addr_sel,
  input wire logic [2:0]  rf_wr_idx,
  input wire logic [31:0] rf_wr_data,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_ack,
  input wire logic [7:0]  mem_rdata,
  input wire logic        ccr_we,
  input wire logic        done,
  input wire logic        illegal
);
  logic [15:0] op_q, adj_q;
  logic [31:0] sv_q, dv_q;
  logic        r1_q;
  logic [7:0]  sb_q;
  wire logic        tk = op_valid & op_ready;
  wire logic        ok = op_word[15:12] == BUP_OP_HI && op_word[8:4] == BUP_OP_MID;
  wire logic        fm = op_q[BUP_FORM_BIT];
  wire logic [15:0] sum = {4'h0, sv_q[7:4], 4'h0, sv_q[3:0]} + adj_q;
  wire logic [15:0] msum = {4'h0, sb_q[7:4], 4'h0, sb_q[3:0]} + adj_q;
  wire logic [31:0] src_ptr = sv_q - 32'h1;
  wire logic [31:0] dst_ptr = dv_q - 32'h2;
  wire logic [31:0] lo_ptr = dv_q - 32'h1;
  wire logic        wr_ok = mem_req & mem_we & mem_ack;
  // First read cycle carries source, second the destination
  always_ff @(posedge clk_sys) begin
    r1_q <= rf_rd_en & rst_b;
    if (tk) op_q <= op_word;
    if (ext_req & ext_ack) adj_q <= ext_word;
    if (rf_rd_en & ~r1_q) sv_q <= rf_rd_data;
    if (rf_rd_en & r1_q) dv_q <= rf_rd_data;
    if (mem_req & ~mem_we & mem_ack) sb_q <= mem_rdata;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_ccr_untouched: assert property (!ccr_we)
    else $error("flags written");
  a_bad_op_flag: assert property (tk && !ok |=> illegal && !ext_req)
    else $error("bad opcode not flagged");
  a_good_op_fetch: assert property (tk && ok |=> ext_req && !illegal)
    else $error("no extension fetch");
  a_form_select: assert property (rf_rd_en |-> rf_rd_addr_sel == fm)
    else $error("wrong register bank");
  a_src_index: assert property (rf_rd_en && !r1_q |-> rf_rd_idx == op_q[2:0])
    else $error("wrong source index");
  a_dst_index: assert property (rf_wr_en |-> rf_wr_idx == op_q[11:9])
    else $error("wrong destination index");
  a_reg_result: assert property (rf_wr_en && !fm |-> rf_wr_data == {dv_q[31:16], sum})
    else $error("register result wrong");
  a_reg_done: assert property (rf_wr_en && !fm |=> done)
    else $error("done late");
  a_mem_src_addr: assert property (mem_req && !mem_we |-> mem_addr == src_ptr)
    else $error("wrong source byte address");
  a_hi_byte: assert property (wr_ok && mem_addr == dst_ptr |-> mem_wdata == msum[15:8])
    else $error("high result byte wrong");
  a_lo_byte: assert property (wr_ok && mem_addr == lo_ptr |-> mem_wdata == msum[7:0])
    else $error("low result byte wrong");
  a_ptr_write: assert property (rf_wr_en && fm |-> rf_wr_addr_sel && rf_wr_data == dst_ptr)
    else $error("destination pointer wrong");
  c_reg: cover property (done && !fm);
  c_mem: cover property (done && fm);
  c_bad: cover property (illegal);
endmodule : bup_checker

bind bup_core bup_checker bup_checker_inst (.*);

/* dv/bup_partner.sv */
// Partner: register file, extension fetch and byte memory
module bup_partner (
  input wire logic        clk_sys,
  input wire logic [15:0] adj,
  input wire logic        ext_req,
  output logic            ext_ack,
  output logic     [15:0] ext_word,
  input wire logic        rf_rd_en,
  input wire logic        rf_rd_addr_sel,
  input wire logic [2:0]  rf_rd_idx,
  output logic     [31:0] rf_rd_data,
  input wire logic        rf_wr_en,
  input wire logic        rf_wr_addr_sel,
  input wire logic [2:0]  rf_wr_idx,
  input wire logic [31:0] rf_wr_data,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  output logic            mem_ack,
  output logic     [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rf [16];
  logic [7:0]  m [256];
  logic [1:0]  w = 2'h0;
  wire logic [31:0] rv = rf[{rf_rd_addr_sel, rf_rd_idx}];
  wire logic [7:0]  mv = m[mem_addr[7:0]];
  // Ack two cycles of three: back-to-back, prompt and one-cycle-late answers
  assign ext_ack = ext_req & (w != 2'h0);
  assign mem_ack = mem_req & (w != 2'h0);
  // Idle lines show inverted data, never a stale copy
  assign ext_word = ext_ack ? adj : ~adj;
  assign rf_rd_data = rf_rd_en ? rv : ~rv;
  assign mem_rdata = mem_ack ? mv : ~mv;
  always @(posedge clk_sys) begin
    w <= (w == 2'h2) ? 2'h0 : w + 2'h1;
    if (rf_wr_en) rf[{rf_wr_addr_sel, rf_wr_idx}] <= rf_wr_data;
    if (mem_ack & mem_we) m[mem_addr[7:0]] <= mem_wdata;
  end
endmodule : bup_partner

/* dv/test_bup_core.sv */
// Testbench: register form, memory form and bad opcode on bup_core
module test_bup_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rst_b = 1'b0, op_valid = 1'b0;
  logic [15:0] op_word = 16'h0000, adj = 16'h0000, ext_word;
  logic        op_ready, ext_req, ext_ack, rf_rd_en, rf_rd_addr_sel, rf_wr_en;
  logic        rf_wr_addr_sel, mem_req, mem_we, mem_ack, ccr_we, done, illegal;
  logic [2:0]  rf_rd_idx, rf_wr_idx;
  logic [31:0] rf_rd_data, rf_wr_data, mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  int          err_count = 0, n_compared = 0;
  bup_core bup_core_inst (.*);
  bup_partner bup_partner_inst (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // One opcode; waits bounded for done or illegal
  task automatic issue(input logic [15:0] op, input logic [15:0] a, output logic ill);
    int n;
    adj = a;
    @(negedge clk_sys);
    op_word = op;
    op_valid = 1'b1;
    @(negedge clk_sys);
    op_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && illegal !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    ill = illegal;
    chk(32'h1, 32'(n < 40));
  endtask : issue
  task automatic t_reg();
    logic il;
    bup_partner_inst.rf[1] = 32'hAABB_CC59;
    bup_partner_inst.rf[2] = 32'h1234_5678;
    issue(16'h8581, 16'h3030, il);
    chk(32'h1234_3539, bup_partner_inst.rf[2]);
    bup_partner_inst.rf[1] = 32'h0000_0099;
    issue(16'h8581, 16'hF0F0, il);
    chk(32'h1234_F9F9, bup_partner_inst.rf[2]);
    $display("test register form ended");
  endtask : t_reg
  task automatic t_mem();
    logic il;
    bup_partner_inst.rf[8] = 32'h0000_0041;
    bup_partner_inst.rf[9] = 32'h0000_0080;
    bup_partner_inst.m[8'h40] = 8'h72;
    bup_partner_inst.m[8'h41] = 8'h11;
    issue(16'h8388, 16'h3030, il);
    chk(32'h37, {24'h0, bup_partner_inst.m[8'h7E]});
    chk(32'h32, {24'h0, bup_partner_inst.m[8'h7F]});
    chk(32'h7E, bup_partner_inst.rf[9]);
    $display("test memory form ended");
  endtask : t_mem
  task automatic t_bad();
    logic il;
    issue(16'h8481, 16'h3030, il);
    chk(32'h1, {31'h0, il});
    chk(32'h1234_F9F9, bup_partner_inst.rf[2]);
    $display("test bad opcode ended");
  endtask : t_bad
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reg();
    t_mem();
    t_bad();
    tally_and_finish();
  end
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
endmodule : test_bup_core
